// ==== dbg_uart_pkg.sv ====
// constants, types and the state record of the autobaud debug serial link
// Contract
// - one start, eight data, one stop, no parity
// - data bits travel least significant bit first
// - no commands until baud rate is measured
// - low time of sync frame divided by 8
// - measured rate kept until next reset
// - command bit 7 set means write
// - command bit 6 set means 8-bit access
// - command bits 5 to 0 give address
// - device answers read command with data frames
// - burst data flows right after start bit
// - burst count sets accesses, decrements, zero single
// - burst address advances by one or two
package dbg_uart_pkg;
    // serial frame shape
    localparam int DATA_BITS = 8;
    localparam int SYNC_DIV_SHIFT = 3;
    localparam int BAUD_CNT_W = 20;
    localparam logic [BAUD_CNT_W-1:0] MIN_PERIOD = 20'h00002;
    // command frame fields
    localparam int CMD_WR_BIT = 7;
    localparam int CMD_BYTE_BIT = 6;
    localparam int CMD_ADDR_W = 6;
    // debug register addresses seen by the burst engine
    localparam logic [5:0] MEMORY_CONTROL_REG_ADDR = 6'h04;
    localparam logic [5:0] MEM_ADDR_ADDR = 6'h05;
    localparam logic [5:0] BURST_COUNT_REG_ADDR = 6'h07;
    // memory_control_reg fields
    localparam int CTL_START_BIT = 0;
    localparam int CTL_WR_BIT = 1;
    localparam int CTL_REG_BIT = 2;
    localparam int CTL_BYTE_BIT = 3;
    // address step per access
    localparam logic [15:0] STEP_BYTE = 16'h0001;
    localparam logic [15:0] STEP_WORD = 16'h0002;
    // apb register map
    localparam int APB_ADDR_W = 8;
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATUS_OFS = 8'h04;
    localparam logic [7:0] PERIOD_OFS = 8'h08;
    localparam logic [7:0] LAST_CMD_OFS = 8'h0C;
    localparam int CTRL_EN_BIT = 0;
    localparam int ST_SYNCED_BIT = 0;
    localparam int ST_TXBUSY_BIT = 1;
    localparam int ST_BURST_BIT = 2;
    localparam int ST_FERR_BIT = 3;
    localparam logic CTRL_EN_RESET = 1'b1;

    // link bring-up phases
    typedef enum logic [1:0] {L_ARM, L_WAIT, L_MEAS, L_RUN} link_e;
    // receiver phases
    typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_e;
    // command protocol phases
    typedef enum logic [3:0] {
        P_CMD, P_WLO, P_WHI, P_RDWAIT, P_TX_LO, P_TX_HI, P_TX_END,
        P_BW_LO, P_BW_HI, P_BW_MEM, P_BR_MEM
    } proto_e;

    // apb request from the master
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [APB_ADDR_W-1:0] paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    // apb answer to the master
    typedef struct packed {
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } apb_rsp_s;

    // access toward the debug register bank
    typedef struct packed {
        logic wr;
        logic rd;
        logic byte_mode;
        logic [CMD_ADDR_W-1:0] addr;
        logic [15:0] wdata;
    } dbg_req_s;

    // access toward cpu memory or cpu registers during a burst
    typedef struct packed {
        logic req;
        logic we;
        logic byte_mode;
        logic cpu_reg;
        logic [15:0] addr;
        logic [15:0] wdata;
    } mem_req_s;

    // whole state of the link block
    typedef struct packed {
        logic rx_s1;
        logic rx_s2;
        logic rx_prev;
        link_e link;
        logic [BAUD_CNT_W-1:0] meas;
        logic [BAUD_CNT_W-1:0] period;
        rx_e rx_st;
        logic [BAUD_CNT_W-1:0] rx_tmr;
        logic [2:0] rx_bit;
        logic [7:0] rx_sh;
        logic rx_valid;
        logic [7:0] rx_byte;
        logic tx_busy;
        logic [BAUD_CNT_W-1:0] tx_tmr;
        logic [3:0] tx_bit;
        logic [9:0] tx_sh;
        logic txd;
        proto_e proto;
        logic [7:0] cmd;
        logic [15:0] wbuf;
        logic cur_byte;
        logic bursting;
        logic [7:0] sh_ctl;
        logic [15:0] sh_addr;
        logic [15:0] sh_cnt;
        dbg_req_s dbg;
        mem_req_s mem;
        logic ctrl_en;
        logic ferr;
        apb_rsp_s apb;
    } state_s;
endpackage

// ==== debug_uart_autobaud_link.sv ====
// autobaud debug serial link with command decoder, burst engine and apb status slave
//
// The implementer's own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module debug_uart_autobaud_link (
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic rxd_in,
    output logic txd_out,
    input wire dbg_uart_pkg::apb_req_s apb_in,
    output dbg_uart_pkg::apb_rsp_s apb_out,
    output dbg_uart_pkg::dbg_req_s dbg_out,
    input wire logic [15:0] dbg_rdata_in,
    output dbg_uart_pkg::mem_req_s mem_out,
    input wire logic mem_ack_in,
    input wire logic [15:0] mem_rdata_in
);
    import dbg_uart_pkg::*;

    state_s cur; // registered state
    state_s nxt; // next state

    // address step of one burst access
    function automatic logic [15:0] step_of(input logic byte_mode);
        step_of = byte_mode ? STEP_BYTE : STEP_WORD;
    endfunction

    // value stored into a 16-bit shadow from a write of either width
    function automatic logic [15:0] wval(input logic byte_mode, input logic [15:0] d);
        wval = byte_mode ? {8'h00, d[7:0]} : d;
    endfunction

    // next state of the whole block
    always_comb begin
        logic tx_go; // launch a frame this cycle
        logic [7:0] tx_data; // byte to launch
        logic rx_ok; // a received byte for the protocol
        logic do_write; // complete a debug write
        logic [BAUD_CNT_W-1:0] half; // half bit period
        logic [CMD_ADDR_W-1:0] waddr; // address of the pending write
        logic [15:0] wdat; // data of the pending write
        logic [15:0] wv; // width-adjusted write value
        logic sel_setup; // apb setup cycle
        logic sel_access; // apb access edge
        logic [7:0] pa; // apb offset
        rx_ok = cur.rx_valid;
        tx_go = 1'b0;
        tx_data = 8'h00;
        do_write = 1'b0;
        waddr = '0;
        wdat = 16'h0000;
        wv = 16'h0000;
        nxt = cur;
        half = cur.period >> 1;
        pa = apb_in.paddr;
        sel_setup = apb_in.psel & ~apb_in.penable;
        sel_access = apb_in.psel & apb_in.penable & cur.apb.pready;

        // two-stage synchroniser on the receive pin
        nxt.rx_s1 = rxd_in;
        nxt.rx_s2 = cur.rx_s1;
        nxt.rx_prev = cur.rx_s2;

        // pulses last one cycle
        nxt.rx_valid = 1'b0;
        nxt.dbg.wr = 1'b0;
        nxt.dbg.rd = 1'b0;

        // baud measurement, done once per reset
        case (cur.link)
            L_ARM: begin
                // wait for an idle high line first
                if (cur.rx_s2) begin
                    nxt.link = L_WAIT;
                end
            end
            L_WAIT: begin
                // falling edge of the sync frame
                if (cur.rx_prev && !cur.rx_s2) begin
                    nxt.link = L_MEAS;
                    nxt.meas = BAUD_CNT_W'(1); // the detecting cycle is already low
                end
            end
            L_MEAS: begin
                if (cur.rx_s2) begin
                    // low time spans eight bit periods
                    nxt.link = L_RUN;
                    nxt.period = ((cur.meas >> SYNC_DIV_SHIFT) < MIN_PERIOD) ?
                                 MIN_PERIOD : (cur.meas >> SYNC_DIV_SHIFT);
                end else if (cur.meas != '1) begin
                    nxt.meas = cur.meas + 1'b1;
                end
            end
            L_RUN: begin
                // rate frozen until reset
                nxt.link = L_RUN;
            end
            default: begin
                nxt.link = L_ARM;
            end
        endcase

        // 8n1 receiver, active only after measurement
        case (cur.rx_st)
            RX_IDLE: begin
                if (cur.link == L_RUN && cur.rx_prev && !cur.rx_s2) begin
                    nxt.rx_st = RX_START;
                    nxt.rx_tmr = half; // aim at mid start bit
                end
            end
            RX_START: begin
                if (cur.rx_tmr != '0) begin
                    nxt.rx_tmr = cur.rx_tmr - 1'b1;
                end else if (!cur.rx_s2) begin
                    nxt.rx_st = RX_DATA;
                    nxt.rx_tmr = cur.period - 1'b1; // one full bit to next middle
                    nxt.rx_bit = 3'h0;
                end else begin
                    // glitch, not a start bit
                    nxt.rx_st = RX_IDLE;
                end
            end
            RX_DATA: begin
                if (cur.rx_tmr != '0) begin
                    nxt.rx_tmr = cur.rx_tmr - 1'b1;
                end else begin
                    // shift in from the top, first bit ends lowest
                    nxt.rx_sh = {cur.rx_s2, cur.rx_sh[7:1]};
                    nxt.rx_tmr = cur.period - 1'b1;
                    nxt.rx_bit = cur.rx_bit + 1'b1;
                    if (cur.rx_bit == 3'(DATA_BITS - 1)) begin
                        nxt.rx_st = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (cur.rx_tmr != '0) begin
                    nxt.rx_tmr = cur.rx_tmr - 1'b1;
                end else begin
                    nxt.rx_st = RX_IDLE;
                    if (cur.rx_s2) begin
                        // good stop bit
                        nxt.rx_valid = cur.ctrl_en;
                        nxt.rx_byte = cur.rx_sh;
                    end else begin
                        nxt.ferr = 1'b1; // framing error
                    end
                end
            end
            default: begin
                nxt.rx_st = RX_IDLE;
            end
        endcase

        // command protocol and burst engine
        case (cur.proto)
            P_CMD: begin
                // every register access opens with a command frame
                if (rx_ok) begin
                    nxt.cmd = cur.rx_byte;
                    nxt.cur_byte = cur.rx_byte[CMD_BYTE_BIT];
                    nxt.dbg.addr = cur.rx_byte[CMD_ADDR_W-1:0];
                    nxt.dbg.byte_mode = cur.rx_byte[CMD_BYTE_BIT];
                    if (cur.rx_byte[CMD_WR_BIT]) begin
                        nxt.proto = P_WLO; // write flag set
                    end else begin
                        nxt.dbg.rd = 1'b1;
                        nxt.proto = P_RDWAIT;
                    end
                end
            end
            P_WLO: begin
                // first data frame is the low byte
                if (rx_ok) begin
                    nxt.wbuf[7:0] = cur.rx_byte;
                    if (cur.cur_byte) begin
                        do_write = 1'b1;
                        waddr = cur.cmd[CMD_ADDR_W-1:0];
                        wdat = {8'h00, cur.rx_byte};
                    end else begin
                        nxt.proto = P_WHI;
                    end
                end
            end
            P_WHI: begin
                if (rx_ok) begin
                    nxt.wbuf[15:8] = cur.rx_byte;
                    do_write = 1'b1;
                    waddr = cur.cmd[CMD_ADDR_W-1:0];
                    wdat = {cur.rx_byte, cur.wbuf[7:0]};
                end
            end
            P_RDWAIT: begin
                // register bank answers in the same cycle as the read strobe
                nxt.wbuf = cur.dbg.byte_mode ? {8'h00, dbg_rdata_in[7:0]} : dbg_rdata_in;
                nxt.proto = P_TX_LO;
            end
            P_TX_LO: begin
                // answer frames, low byte first
                if (!cur.tx_busy) begin
                    tx_go = 1'b1;
                    tx_data = cur.wbuf[7:0];
                    nxt.proto = cur.cur_byte ? P_TX_END : P_TX_HI;
                end
            end
            P_TX_HI: begin
                if (!cur.tx_busy) begin
                    tx_go = 1'b1;
                    tx_data = cur.wbuf[15:8];
                    nxt.proto = P_TX_END;
                end
            end
            P_TX_END: begin
                if (cur.bursting && cur.sh_cnt != 16'h0000) begin
                    // next burst read
                    nxt.mem.req = 1'b1;
                    nxt.mem.we = 1'b0;
                    nxt.mem.addr = cur.sh_addr;
                    nxt.proto = P_BR_MEM;
                end else begin
                    nxt.bursting = 1'b0;
                    nxt.proto = P_CMD;
                end
            end
            P_BW_LO: begin
                // burst data arrives with no register access
                if (rx_ok) begin
                    nxt.wbuf[7:0] = cur.rx_byte;
                    if (cur.cur_byte) begin
                        nxt.mem.req = 1'b1;
                        nxt.mem.we = 1'b1;
                        nxt.mem.addr = cur.sh_addr;
                        nxt.mem.wdata = {8'h00, cur.rx_byte};
                        nxt.proto = P_BW_MEM;
                    end else begin
                        nxt.proto = P_BW_HI;
                    end
                end
            end
            P_BW_HI: begin
                if (rx_ok) begin
                    nxt.wbuf[15:8] = cur.rx_byte;
                    nxt.mem.req = 1'b1;
                    nxt.mem.we = 1'b1;
                    nxt.mem.addr = cur.sh_addr;
                    nxt.mem.wdata = {cur.rx_byte, cur.wbuf[7:0]};
                    nxt.proto = P_BW_MEM;
                end
            end
            P_BW_MEM: begin
                // hold the request until memory takes it
                if (mem_ack_in) begin
                    nxt.mem.req = 1'b0;
                    nxt.sh_addr = cur.sh_addr + step_of(cur.cur_byte);
                    nxt.sh_cnt = cur.sh_cnt - 16'h0001;
                    if (cur.sh_cnt == 16'h0001) begin
                        nxt.bursting = 1'b0;
                        nxt.proto = P_CMD;
                    end else begin
                        nxt.proto = P_BW_LO;
                    end
                end
            end
            P_BR_MEM: begin
                if (mem_ack_in) begin
                    nxt.mem.req = 1'b0;
                    nxt.wbuf = cur.cur_byte ? {8'h00, mem_rdata_in[7:0]} : mem_rdata_in;
                    nxt.sh_addr = cur.sh_addr + step_of(cur.cur_byte);
                    nxt.sh_cnt = cur.sh_cnt - 16'h0001;
                    nxt.proto = P_TX_LO; // stream straight out
                end
            end
            default: begin
                nxt.proto = P_CMD;
            end
        endcase

        // completed debug write, shadowing the burst registers
        if (do_write) begin
            wv = wval(cur.cur_byte, wdat);
            nxt.dbg.wr = 1'b1;
            nxt.dbg.addr = waddr;
            nxt.dbg.wdata = wv;
            nxt.proto = P_CMD;
            if (waddr == MEM_ADDR_ADDR) begin
                nxt.sh_addr = wv;
            end
            if (waddr == BURST_COUNT_REG_ADDR) begin
                nxt.sh_cnt = wv;
            end
            if (waddr == MEMORY_CONTROL_REG_ADDR) begin
                nxt.sh_ctl = wv[7:0];
                // nonzero count turns the start into a burst
                if (wv[CTL_START_BIT] && cur.sh_cnt != 16'h0000) begin
                    nxt.bursting = 1'b1;
                    nxt.cur_byte = wv[CTL_BYTE_BIT];
                    nxt.mem.byte_mode = wv[CTL_BYTE_BIT];
                    nxt.mem.cpu_reg = wv[CTL_REG_BIT];
                    if (wv[CTL_WR_BIT]) begin
                        nxt.proto = P_BW_LO;
                    end else begin
                        nxt.mem.req = 1'b1;
                        nxt.mem.we = 1'b0;
                        nxt.mem.addr = cur.sh_addr;
                        nxt.proto = P_BR_MEM;
                    end
                end
            end
        end

        // 8n1 transmitter, start bit then data lsb first
        if (tx_go) begin
            nxt.tx_busy = 1'b1;
            nxt.tx_sh = {1'b1, tx_data, 1'b0};
            nxt.txd = 1'b0;
            nxt.tx_bit = 4'h0;
            nxt.tx_tmr = cur.period - 1'b1;
        end else if (cur.tx_busy) begin
            if (cur.tx_tmr != '0) begin
                nxt.tx_tmr = cur.tx_tmr - 1'b1;
            end else if (cur.tx_bit == 4'(DATA_BITS + 1)) begin
                // stop bit has run its full period
                nxt.tx_busy = 1'b0;
            end else begin
                nxt.tx_sh = {1'b1, cur.tx_sh[9:1]};
                nxt.txd = cur.tx_sh[1];
                nxt.tx_bit = cur.tx_bit + 1'b1;
                nxt.tx_tmr = cur.period - 1'b1;
            end
        end

        // apb slave: decode in setup, answer in access
        nxt.apb.pready = 1'b0;
        if (sel_setup) begin
            nxt.apb.pready = 1'b1;
            nxt.apb.pslverr = 1'b0;
            nxt.apb.prdata = 32'h00000000;
            case (pa)
                CTRL_OFS: begin
                    nxt.apb.prdata[CTRL_EN_BIT] = cur.ctrl_en;
                end
                STATUS_OFS: begin
                    nxt.apb.prdata[ST_SYNCED_BIT] = (cur.link == L_RUN);
                    nxt.apb.prdata[ST_TXBUSY_BIT] = cur.tx_busy;
                    nxt.apb.prdata[ST_BURST_BIT] = cur.bursting;
                    nxt.apb.prdata[ST_FERR_BIT] = cur.ferr;
                end
                PERIOD_OFS: begin
                    nxt.apb.prdata[BAUD_CNT_W-1:0] = cur.period;
                end
                LAST_CMD_OFS: begin
                    nxt.apb.prdata[7:0] = cur.cmd;
                end
                default: begin
                    // unmapped offset
                    nxt.apb.pslverr = 1'b1;
                end
            endcase
        end
        if (sel_access && apb_in.pwrite) begin
            if (pa == CTRL_OFS) begin
                nxt.ctrl_en = apb_in.pwdata[CTRL_EN_BIT];
            end
            // write one clears, a new error in the same cycle wins
            if (pa == STATUS_OFS && apb_in.pwdata[ST_FERR_BIT] &&
                !(cur.rx_st == RX_STOP && cur.rx_tmr == '0 && !cur.rx_s2)) begin
                nxt.ferr = 1'b0;
            end
        end
    end

    // state register, constants only under reset
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cur <= '0;
            cur.rx_s1 <= 1'b1;
            cur.rx_s2 <= 1'b1;
            cur.rx_prev <= 1'b1;
            cur.link <= L_ARM;
            cur.rx_st <= RX_IDLE;
            cur.tx_sh <= 10'h3FF;
            cur.txd <= 1'b1;
            cur.proto <= P_CMD;
            cur.ctrl_en <= CTRL_EN_RESET;
            cur.period <= MIN_PERIOD;
        end else begin
            cur <= nxt;
        end
    end

    // outputs straight from the state register
    assign txd_out = cur.txd;
    assign apb_out = cur.apb;
    assign dbg_out = cur.dbg;
    assign mem_out = cur.mem;
endmodule
`default_nettype wire

// ==== host_serial_model.sv ====
// host side serial model: sends 8n1 frames and hears device frames
`timescale 1ns/10ps
`default_nettype none
module host_serial_model #(parameter int P = 16) (
    input wire logic clock_in,
    input wire logic txd_in,
    output logic rxd_out
);
    logic [7:0] got[$]; // bytes heard from the device
    logic [7:0] v; // byte being heard
    // line idles high
    initial rxd_out = 1'b1;
    // one frame: start low, data lsb first, stop high
    task automatic send(input logic [7:0] d);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clock_in) rxd_out <= f[i];
            repeat (P - 1) @(posedge clock_in);
        end
    endtask
    // listener samples mid bit and drops frames with a bad stop
    always begin
        @(negedge txd_in);
        repeat (P / 2) @(posedge clock_in);
        for (int i = 0; i < 9; i++) begin
            repeat (P) @(posedge clock_in);
            if (i < 8) v[i] = txd_in;
            else if (txd_in) got.push_back(v);
        end
    end
endmodule
`default_nettype wire

// ==== dbg_link_checker.sv ====
// concurrent checks on the debug serial link ports
`timescale 1ns/10ps
`default_nettype none
module dbg_link_checker
    import dbg_uart_pkg::*;
(
    input wire logic clock_in,
    input wire logic resetn_in,
    input wire logic rxd_in,
    input wire logic txd_out,
    input wire apb_req_s apb_in,
    input wire apb_rsp_s apb_out,
    input wire dbg_req_s dbg_out,
    input wire mem_req_s mem_out,
    input wire logic mem_ack_in
);
    logic synced; // sync frame over
    logic [19:0] meas; // sync low time, frozen once synced
    logic [19:0] low; // cycles the transmit pin has been low
    // own sync measurement and transmit low-run counter
    always_ff @(posedge clock_in or negedge resetn_in) begin
        if (!resetn_in) begin
            synced <= 1'b0;
            meas <= '0;
            low <= '0;
        end else begin
            low <= txd_out ? '0 : low + 20'h00001;
            if (!synced) meas <= meas + {19'h0, !rxd_in};
            if (!synced && rxd_in && meas != '0) synced <= 1'b1;
        end
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!resetn_in);
    reset_quiet_a: assert property ($rose(resetn_in) |-> txd_out && !mem_out.req)
        else $error("outputs busy after reset");
    idle_unsynced_a: assert property (!synced |-> txd_out && !dbg_out.wr && !dbg_out.rd)
        else $error("activity before sync");
    bit_time_a: assert property (synced && $rose(txd_out) |-> low % (meas >> 3) == '0)
        else $error("tx bit not a whole period");
    read_answer_a: assert property ($rose(dbg_out.rd) |-> ##[1:4] !txd_out)
        else $error("no answer to read");
    one_access_a: assert property (!(dbg_out.wr && dbg_out.rd))
        else $error("read and write at once");
    wr_pulse_a: assert property (dbg_out.wr |=> !dbg_out.wr)
        else $error("write strobe too long");
    mem_hold_a: assert property (mem_out.req && !mem_ack_in |=>
        mem_out.req && $stable(mem_out.addr)) else $error("memory request dropped");
    apb_ready_a: assert property (apb_in.psel && !apb_in.penable |=> apb_out.pready)
        else $error("apb answer late");
endmodule
bind debug_uart_autobaud_link dbg_link_checker chk (.clock_in(clock_in),
    .resetn_in(resetn_in), .rxd_in(rxd_in), .txd_out(txd_out), .apb_in(apb_in),
    .apb_out(apb_out), .dbg_out(dbg_out), .mem_out(mem_out), .mem_ack_in(mem_ack_in));
`default_nettype wire

// ==== debug_uart_autobaud_link_tb.sv ====
// bench for the autobaud debug serial link
`timescale 1ns/10ps
`default_nettype none
module debug_uart_autobaud_link_tb;
    import dbg_uart_pkg::*;
    localparam int P = 16; // bit period in clocks
    logic clock_in, resetn_in, rxd, txd, mem_ack, err;
    logic [15:0] dbg_rdata; // debug bank answer
    logic [31:0] rd; // apb read data
    apb_req_s req;
    apb_rsp_s apb_out;
    dbg_req_s dbg_out;
    mem_req_s mem_out;
    dbg_req_s wq[$]; // debug writes seen
    mem_req_s mq[$]; // memory accesses seen
    int error_cnt = 0;
    int checks_done = 0;
    debug_uart_autobaud_link uut (.clock_in(clock_in), .resetn_in(resetn_in),
        .rxd_in(rxd), .txd_out(txd), .apb_in(req), .apb_out(apb_out), .dbg_out(dbg_out),
        .dbg_rdata_in(dbg_rdata), .mem_out(mem_out), .mem_ack_in(mem_ack),
        .mem_rdata_in(mem_out.addr));
    host_serial_model #(.P(P)) host (.clock_in(clock_in), .txd_in(txd), .rxd_out(rxd));
    initial begin
        clock_in = 1'b0;
        forever #2.5 clock_in = ~clock_in;
    end
    // memory partner acks in one cycle; strobes are logged
    always @(posedge clock_in) begin
        mem_ack <= mem_out.req && !mem_ack;
        if (mem_out.req && mem_ack) mq.push_back(mem_out);
        if (dbg_out.wr === 1'b1) wq.push_back(dbg_out);
    end
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask
    // one apb transfer, held until pready
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge clock_in);
        req.penable <= 1'b1;
        while (apb_out.pready !== 1'b1) @(posedge clock_in);
        rd = apb_out.prdata;
        err = apb_out.pslverr;
        req <= '0;
    endtask
    // wait for a byte from the device
    task automatic hear(input logic [7:0] e);
        int n;
        for (n = 0; n < 20 * P && host.got.size() == 0; n++) @(posedge clock_in);
        chk("tx byte", e, host.got.size() ? host.got.pop_front() : 8'hXX);
    endtask
    // serial register write and its strobe
    task automatic wreg(input logic [5:0] a, input logic [15:0] d, input logic bm);
        dbg_req_s w;
        host.send({1'b1, bm, a});
        host.send(d[7:0]);
        if (!bm) host.send(d[15:8]);
        repeat (P) @(posedge clock_in);
        w = wq.size() ? wq.pop_front() : 'x;
        chk("wr", {bm, a, bm ? {8'h00, d[7:0]} : d}, {w.byte_mode, w.addr, w.wdata});
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // reset values, unmapped offset, then the sync frame
    task automatic t_bringup();
        apb(1'b0, CTRL_OFS, '0);
        chk("ctrl", 32'h00000001, rd);
        apb(1'b0, STATUS_OFS, '0);
        chk("status", 32'h00000000, rd);
        apb(1'b0, 8'h10, '0);
        chk("unmapped", 32'h00000001, {31'h0, err});
        host.send(8'h80);
        repeat (8) @(posedge clock_in);
        apb(1'b0, PERIOD_OFS, '0);
        chk("period", P, rd);
        $display("test bringup done");
    endtask
    task automatic t_write();
        wreg(6'h12, 16'h1234, 1'b0);
        wreg(6'h21, 16'h77A5, 1'b1);
        apb(1'b0, LAST_CMD_OFS, '0);
        chk("last cmd", 32'h000000E1, rd);
        $display("test write done");
    endtask
    task automatic t_read();
        dbg_rdata <= 16'hBEEF;
        host.send(8'h13);
        hear(8'hEF);
        hear(8'hBE);
        host.send(8'h55);
        hear(8'hEF);
        $display("test read done");
    endtask
    // word write burst, byte read burst, then a zero count
    task automatic t_burst();
        wreg(BURST_COUNT_REG_ADDR, 16'h0002, 1'b0);
        wreg(MEM_ADDR_ADDR, 16'h0200, 1'b0);
        wreg(MEMORY_CONTROL_REG_ADDR, 16'h0003, 1'b1);
        for (int i = 1; i < 3; i++) begin
            host.send(8'(8'h11 * i));
            host.send(8'(8'h22 * i));
        end
        repeat (P) @(posedge clock_in);
        chk("bw n", 2, mq.size());
        for (int i = 0; i < 2; i++) begin
            chk("bw", 32'h02002211 + 32'h00022211 * i, {mq[i].addr, mq[i].wdata});
        end
        mq.delete();
        wreg(BURST_COUNT_REG_ADDR, 16'h0003, 1'b0);
        wreg(MEM_ADDR_ADDR, 16'h0300, 1'b0);
        wreg(MEMORY_CONTROL_REG_ADDR, 16'h0009, 1'b1);
        for (int i = 0; i < 3; i++) begin
            hear(8'(i));
            chk("br", 32'h00010300 + i, {mq[i].we, mq[i].byte_mode, mq[i].addr});
        end
        mq.delete();
        wreg(BURST_COUNT_REG_ADDR, 16'h0000, 1'b0);
        wreg(MEMORY_CONTROL_REG_ADDR, 16'h0001, 1'b1);
        chk("single", 0, mq.size());
        apb(1'b0, PERIOD_OFS, '0);
        chk("period kept", P, rd);
        $display("test burst done");
    endtask
    initial begin
        resetn_in = 1'b0;
        req = '0;
        mem_ack = 1'b0;
        dbg_rdata = 16'h0000;
        repeat (4) @(posedge clock_in);
        resetn_in <= 1'b1;
        t_bringup();
        t_write();
        t_read();
        t_burst();
        end_of_test();
    end
    // watchdog against a hang
    initial begin
        repeat (30000) @(posedge clock_in);
        error_cnt++;
        end_of_test();
    end
endmodule
`default_nettype wire
